// >>> rtl/lhp_port.sv
// Host port, display RAM addressing and refresh read port of the display controller
// Contract
// - Parallel bus when interface select high, else serial
// - Serial mode never drives data back
// - Bus style pin picks 6800 or 8080 strobes
// - Select high is data, low is command/status
// - Deselected chip floats bus, ignores strobes
// - Serial sampled rising edge, MSB first, byte on eighth
// - Select sampled each eighth serial edge
// - Deselect resets shift register and counter
// - Reads pipelined through holder, data one late
// - Write captured in holder, then committed
// - Busy flag on D7, only status accepted
// - Byte is one column, D0 lowest line
// - Page 8 keeps only bit D0
// - Page address changes only by command
// - Column increments after each data access
// - Column stops at last column, no wrap
// - Segment direction reverses column mapping
// - Start line drives top row, scan direction aware
// - 65 lines from start line, scroll at once
// - Refresh port independent of host port
`include "lhp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lhp_port #(
  parameter int BUSY_CYC = `LHP_BUSY_CYC
) (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_interface_select,
  input  wire logic       i_bus_style_select,
  input  wire logic       i_chip_select_low_n,
  input  wire logic       i_chip_select_high,
  input  wire logic       i_data_cmd_select,
  input  wire logic       i_read_strobe,
  input  wire logic       i_write_strobe,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  input  wire logic       i_serial_clock,
  input  wire logic       i_serial_data,
  input  wire logic       i_com_reverse,
  input  wire logic [6:0] i_refresh_com,
  input  wire logic [7:0] i_refresh_seg,
  output logic            o_refresh_bit,
  output logic            o_busy
);
  // Busy time has to fit the 8-bit down-counter and be at least one cycle
  if (BUSY_CYC < 1 || BUSY_CYC > 255) begin : g_busy_cyc_bad
    $error("BUSY_CYC out of range");
  end

  // ---------------- Serial link domain ----------------
  logic       sel_pin;
  logic       ser_rst_n;
  logic [6:0] ser_shift_q;
  logic [2:0] ser_cnt_q;
  logic [7:0] ser_byte_q;
  logic       ser_dc_q;
  logic       ser_tgl_q;

  // Deselect acts as reset so every selection starts on a byte boundary
  assign sel_pin   = ~i_chip_select_low_n & i_chip_select_high;
  assign ser_rst_n = i_arst_n & sel_pin & ~i_interface_select;

  // Shift in MSB first on rising serial edges
  always_ff @(posedge i_serial_clock or negedge ser_rst_n) begin
    if (!ser_rst_n) begin
      ser_shift_q <= 7'h00;
      ser_cnt_q   <= 3'h0;
    end else begin
      ser_shift_q <= {ser_shift_q[5:0], i_serial_data};
      ser_cnt_q   <= ser_cnt_q + 3'h1;
    end
  end

  // Byte hand-off; kept through deselect so the toggle stays honest
  always_ff @(posedge i_serial_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ser_byte_q <= 8'h00;
      ser_dc_q   <= 1'b0;
      ser_tgl_q  <= 1'b0;
    end else if (ser_cnt_q == 3'h7 && ser_rst_n) begin
      ser_byte_q <= {ser_shift_q, i_serial_data};
      ser_dc_q   <= i_data_cmd_select;
      ser_tgl_q  <= ~ser_tgl_q;
    end
  end

  // ---------------- Pin synchronisers ----------------
  // Toggle rides with the pins so one flop pair serves both crossings
  localparam int SW = 16;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  assign pin_raw = {ser_tgl_q, i_interface_select, i_bus_style_select, i_chip_select_low_n,
                    i_chip_select_high, i_data_cmd_select, i_read_strobe, i_write_strobe,
                    i_data};

  // Two flops before any system-clock host logic looks at a bus pin; serial and refresh inputs are used directly
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic       tgl_s, par_s, style_s, sel_s, dc_s, rd_s, wr_s;
  logic [7:0] data_s;
  assign {tgl_s, par_s, style_s} = sync2_q[15:13];
  assign sel_s  = ~sync2_q[12] & sync2_q[11];
  assign dc_s   = sync2_q[10];
  assign rd_s   = sync2_q[9];
  assign wr_s   = sync2_q[8];
  assign data_s = sync2_q[7:0];

  // Strobe decode: 6800 uses enable plus direction, 8080 separate low strobes
  logic rd_act, wr_act;
  always_comb begin
    if (style_s) begin
      rd_act = rd_s & wr_s;
      wr_act = rd_s & ~wr_s;
    end else begin
      rd_act = ~rd_s;
      wr_act = ~wr_s;
    end
    rd_act = rd_act & sel_s & par_s;
    wr_act = wr_act & sel_s & par_s;
  end

  logic       rd_prev_q, wr_prev_q, tgl_prev_q;
  logic [7:0] wdata_q;
  logic       wdc_q, rdc_q;

  // Data and select tracked while the strobe is active, used at its trailing edge
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_prev_q  <= 1'b0;
      wr_prev_q  <= 1'b0;
      tgl_prev_q <= 1'b0;
      wdata_q    <= 8'h00;
      wdc_q      <= 1'b0;
      rdc_q      <= 1'b0;
    end else begin
      rd_prev_q  <= rd_act;
      wr_prev_q  <= wr_act;
      tgl_prev_q <= tgl_s;
      if (wr_act) begin
        wdata_q <= data_s;
        wdc_q   <= dc_s;
      end
      if (rd_act) begin
        rdc_q <= dc_s;
      end
    end
  end

  // Merge host events from both links
  lhp_pkg::lhp_host_ev_s ev;
  logic                  rd_lead;
  assign rd_lead = rd_act & ~rd_prev_q;
  always_comb begin
    ev = '0;
    if (wr_prev_q && !wr_act) begin
      ev = '{valid: 1'b1, is_data: wdc_q, is_read: 1'b0, value: wdata_q};
    end else if (rd_prev_q && !rd_act) begin
      ev = '{valid: 1'b1, is_data: rdc_q, is_read: 1'b1, value: 8'h00};
    end else if (tgl_s != tgl_prev_q && !par_s) begin
      ev = '{valid: 1'b1, is_data: ser_dc_q, is_read: 1'b0, value: ser_byte_q};
    end
  end

  // ---------------- Controller core ----------------
  lhp_pkg::lhp_state_e state_q;
  logic [7:0] busy_cnt_q;
  logic       busy;
  logic       accept;
  assign busy   = (state_q != lhp_pkg::LHP_IDLE);
  assign accept = ev.valid && !busy && !(ev.is_read && !ev.is_data);
  assign o_busy = busy;

  // Busy sequencing: commit step for data writes, then a fixed busy time
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q    <= lhp_pkg::LHP_IDLE;
      busy_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        lhp_pkg::LHP_IDLE: begin
          if (accept && ev.is_data && !ev.is_read) begin
            state_q <= lhp_pkg::LHP_COMMIT;
          end else if (accept) begin
            state_q    <= lhp_pkg::LHP_BUSY;
            busy_cnt_q <= 8'(BUSY_CYC - 1);
          end
        end
        lhp_pkg::LHP_COMMIT: begin
          state_q    <= lhp_pkg::LHP_BUSY;
          busy_cnt_q <= 8'(BUSY_CYC - 1);
        end
        lhp_pkg::LHP_BUSY: begin
          if (busy_cnt_q == 8'h00) begin
            state_q <= lhp_pkg::LHP_IDLE;
          end else begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
          end
        end
        default: state_q <= lhp_pkg::LHP_IDLE;
      endcase
    end
  end

  logic [3:0] page_q;
  logic [7:0] col_q;
  logic [5:0] start_q;
  logic       seg_rev_q;
  logic       col_step;
  logic       is_cmd;
  assign is_cmd   = accept && !ev.is_data && !ev.is_read;
  assign col_step = (accept && ev.is_data && ev.is_read) ||
                    (state_q == lhp_pkg::LHP_COMMIT);

  // Addresses and settings from commands; column steps on data access
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      page_q    <= 4'h0;
      col_q     <= 8'h00;
      start_q   <= 6'h00;
      seg_rev_q <= 1'b0;
    end else begin
      if (is_cmd && ev.value[7:4] == `LHP_CMD_PAGE && ev.value[3:0] <= `LHP_EXTRA_PAGE) begin
        page_q <= ev.value[3:0];
      end
      if (is_cmd && ev.value[7:4] == `LHP_CMD_COL_HI) begin
        col_q <= {ev.value[3:0], col_q[3:0]};
      end else if (is_cmd && ev.value[7:4] == `LHP_CMD_COL_LO) begin
        col_q <= {col_q[7:4], ev.value[3:0]};
      end else if (col_step && col_q < `LHP_LAST_COL) begin
        col_q <= col_q + 8'h01;
      end
      if (is_cmd && ev.value[7:6] == `LHP_CMD_LINE) begin
        start_q <= ev.value[5:0];
      end
      if (is_cmd && ev.value[7:1] == `LHP_CMD_SEG_DIR) begin
        seg_rev_q <= ev.value[0];
      end
    end
  end

  // Display RAM: one byte per column and page, D0 at the lowest line
  logic [7:0] mem [`LHP_PAGES][`LHP_COLS];
  logic [7:0] holder_q;
  logic [7:0] page_mask;
  logic       addr_ok;
  assign page_mask = (page_q == `LHP_EXTRA_PAGE) ? `LHP_EXTRA_MASK : 8'hff;
  assign addr_ok   = (col_q <= `LHP_LAST_COL);

  // Host side port: write commit from holder, read fetch into holder
  always_ff @(posedge i_clock) begin
    if (state_q == lhp_pkg::LHP_COMMIT && addr_ok) begin
      mem[page_q][col_q] <= holder_q & page_mask;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      holder_q <= 8'h00;
    end else if (accept && ev.is_data && !ev.is_read) begin
      holder_q <= ev.value;
    end else if (accept && ev.is_data && ev.is_read) begin
      holder_q <= addr_ok ? (mem[page_q][col_q] & page_mask) : 8'h00;
    end
  end

  // Read data: holder for data reads, status with busy on D7
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= 8'h00;
    end else if (rd_lead) begin
      o_data <= dc_s ? holder_q : (8'h00 | (8'(busy) << `LHP_BUSY_BIT));
    end
  end

  // Drive only while a selected parallel read strobe is active
  assign o_data_oe = rd_act;

  // Refresh side port, separate from host accesses
  logic [6:0] row;
  logic [7:0] line_sum;
  logic [6:0] line;
  logic [7:0] col_r;
  always_comb begin
    if (i_com_reverse && i_refresh_com < `LHP_IND_ROW) begin
      row = `LHP_LAST_ROW - i_refresh_com;
    end else begin
      row = i_refresh_com;
    end
    line_sum = {2'b00, start_q} + {1'b0, row};
    if (line_sum >= {1'b0, `LHP_LINES}) begin
      line = 7'(line_sum - {1'b0, `LHP_LINES});
    end else begin
      line = line_sum[6:0];
    end
    col_r = seg_rev_q ? (`LHP_LAST_COL - i_refresh_seg) : i_refresh_seg;
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_refresh_bit <= 1'b0;
    end else if (col_r <= `LHP_LAST_COL && line < `LHP_LINES) begin
      o_refresh_bit <= mem[line[6:3]][col_r][line[2:0]];
    end else begin
      o_refresh_bit <= 1'b0;
    end
  end

  // ---------------- Checks ----------------
  sequence s_data_write;
    accept && ev.is_data && !ev.is_read;
  endsequence
  sequence s_commit;
    state_q == lhp_pkg::LHP_COMMIT ##1 state_q == lhp_pkg::LHP_BUSY;
  endsequence
  sequence s_status_read;
    rd_lead && !dc_s;
  endsequence

  chk_write_commit: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s_data_write |=> s_commit) else $error("data write not committed");
  chk_busy_blocks: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    busy |-> !accept) else $error("event accepted while busy");
  chk_col_stop: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    col_q == `LHP_LAST_COL && !is_cmd |=> col_q == `LHP_LAST_COL)
    else $error("column moved past last");
  chk_col_step: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    col_step && !is_cmd && col_q < `LHP_LAST_COL |=> col_q == $past(col_q) + 8'h01)
    else $error("column did not step");
  chk_page_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !is_cmd |=> $stable(page_q)) else $error("page changed without command");
  chk_serial_quiet: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !par_s |-> !o_data_oe) else $error("bus driven in serial mode");
  chk_desel_float: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !sel_s |-> !o_data_oe && !wr_act) else $error("deselected chip active");
  chk_line_wrap: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    line < `LHP_LINES) else $error("line address out of range");
  chk_busy_time: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    accept && !ev.is_data |=> busy [*1] ##[0:255] !busy) else $error("busy stuck");
  chk_extra_page: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    state_q == lhp_pkg::LHP_COMMIT && page_q == `LHP_EXTRA_PAGE && addr_ok
      |=> mem[`LHP_EXTRA_PAGE][$past(col_q)][7:1] == 7'h00)
    else $error("extra page kept upper bits");
  chk_status_busy: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    s_status_read |=> o_data == {$past(busy), 7'h00})
    else $error("status byte does not carry busy");
  chk_busy_drop: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    busy && ev.valid |=> $stable(holder_q)) else $error("event taken while busy");
  chk_serial_take: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    tgl_s != tgl_prev_q && !par_s && !busy |-> accept && ev.is_data == ser_dc_q)
    else $error("serial byte lost or mistyped");
endmodule
`default_nettype wire

// >>> rtl/lhp_map.svh
// Offsets, field positions, command codes and timing figures of the host port
`ifndef LHP_MAP_SVH
`define LHP_MAP_SVH
`define LHP_DATA_W        8
`define LHP_COLS          132
`define LHP_LAST_COL      8'h83
`define LHP_PAGES         9
`define LHP_LINES         7'h41
`define LHP_LAST_ROW      7'h3f
`define LHP_IND_ROW       7'h40
`define LHP_EXTRA_PAGE    4'h8
`define LHP_EXTRA_MASK    8'h01
`define LHP_BUSY_BIT      7
`define LHP_CMD_PAGE      4'hb
`define LHP_CMD_COL_HI    4'h1
`define LHP_CMD_COL_LO    4'h0
`define LHP_CMD_LINE      2'h1
`define LHP_CMD_SEG_DIR   7'h50
`define LHP_CLK_NS        40
`define LHP_BUSY_NS       80
`define LHP_BUSY_CYC      ((`LHP_BUSY_NS + `LHP_CLK_NS - 1) / `LHP_CLK_NS)
`endif

// >>> rtl/lhp_pkg.sv
// Shared types of the host port
package lhp_pkg;
  typedef struct packed {
    logic       valid;
    logic       is_data;
    logic       is_read;
    logic [7:0] value;
  } lhp_host_ev_s;
  typedef enum logic [1:0] {
    LHP_IDLE   = 2'b00,
    LHP_COMMIT = 2'b01,
    LHP_BUSY   = 2'b10
  } lhp_state_e;
endpackage

// >>> dv/lhp_host_model.sv
// Host processor model: parallel bus cycles and serial link bytes
`timescale 1ns/1ps
`default_nettype none
module lhp_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_style,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  output logic            o_cs_n,
  output logic            o_cs_hi,
  output logic            o_dc,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_data,
  output logic            o_sclk,
  output logic            o_sdata
);
  // Selected, 8080 idle, serial clock still
  initial begin
    o_cs_n = 1'b0;
    o_cs_hi = 1'b1;
    o_dc = 1'b1;
    o_rd = 1'b1;
    o_wr = 1'b1;
    o_data = 8'h00;
    o_sclk = 1'b0;
    o_sdata = 1'b0;
  end
  // Chip select levels, then settle
  task automatic sel(input logic lo_n, input logic hi);
    @(posedge i_clock);
    o_cs_n <= lo_n;
    o_cs_hi <= hi;
    repeat (4) @(posedge i_clock);
  endtask
  // Inactive strobe levels for the style in force
  task automatic idle();
    @(posedge i_clock);
    o_rd <= ~i_style;
    o_wr <= 1'b1;
  endtask
  // One bus cycle; floating bus comes back unknown
  task automatic cyc(input logic rd, input logic dc, input logic [7:0] v,
                     output logic [7:0] q);
    @(posedge i_clock);
    o_dc <= dc;
    o_data <= v;
    o_wr <= rd;
    o_rd <= i_style | ~rd;
    repeat (6) @(posedge i_clock);
    q = i_data_oe ? i_data : 8'hxx;
    // Strobe drops before direction, so 6800 writes end cleanly
    o_rd <= ~i_style;
    o_wr <= i_style ? rd : 1'b1;
    repeat (3) @(posedge i_clock);
    o_wr <= 1'b1;
    o_data <= ~v;
    repeat (12) @(posedge i_clock);
  endtask
  // Serial byte, MSB first, n bits; clock runs only here
  task automatic sbyte(input logic dc, input logic [7:0] v, input int n);
    @(posedge i_clock);
    #7;
    o_dc = dc;
    for (int i = 7; i > 7 - n; i--) begin
      o_sdata = v[i];
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
    o_sdata = ~o_sdata;
    repeat (14) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// >>> dv/lhp_port_tb.sv
// Self-checking bench of the display host port
`timescale 1ns/1ps
`default_nettype none
module lhp_port_tb;
  logic       clk;
  logic       rst_n;
  logic       ifs;
  logic       sty;
  logic       crev;
  logic [6:0] rcom;
  logic [7:0] rseg;
  logic       cs_n, cs_hi, dc, rd, wr, sclk, sdat, oe, rbit, busy;
  logic [7:0] hd, od, q, e;
  logic [7:0] d [4];
  int         fails = 0;
  int         n_compared = 0;

  lhp_port #(.BUSY_CYC(2)) dut_u (
    .i_clock(clk), .i_arst_n(rst_n), .i_interface_select(ifs),
    .i_bus_style_select(sty), .i_chip_select_low_n(cs_n),
    .i_chip_select_high(cs_hi), .i_data_cmd_select(dc), .i_read_strobe(rd),
    .i_write_strobe(wr), .i_data(hd), .o_data(od), .o_data_oe(oe),
    .i_serial_clock(sclk), .i_serial_data(sdat), .i_com_reverse(crev),
    .i_refresh_com(rcom), .i_refresh_seg(rseg), .o_refresh_bit(rbit),
    .o_busy(busy));

  lhp_host_model host_u (
    .i_clock(clk), .i_style(sty), .i_data(od), .i_data_oe(oe),
    .o_cs_n(cs_n), .o_cs_hi(cs_hi), .o_dc(dc), .o_rd(rd), .o_wr(wr),
    .o_data(hd), .o_sclk(sclk), .o_sdata(sdat));

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    n_compared++;
    if (s !== x) begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
      fails++;
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Expected memory line shown on a common row
  function automatic int line_of(int com, int start, logic rev);
    return (start + (rev ? 63 - com : com)) % 65;
  endfunction

  task automatic cmd(input logic [7:0] v);
    host_u.cyc(1'b0, 1'b0, v, q);
  endtask
  task automatic wd(input logic [7:0] v);
    host_u.cyc(1'b0, 1'b1, v, q);
  endtask
  task automatic rdd();
    host_u.cyc(1'b1, 1'b1, 8'h00, q);
  endtask
  // Page and column, then, when dum is set, the dummy read that data reads after an address set need
  task automatic at(input logic [3:0] p, input logic [7:0] c, input logic dum);
    cmd({4'hb, p});
    cmd({4'h1, c[7:4]});
    cmd({4'h0, c[3:0]});
    if (dum) rdd();
  endtask
  // Refresh pixel probe, one cycle of latency
  task automatic rf(input int com, input int seg, input logic x);
    @(posedge clk);
    rcom <= 7'(com);
    rseg <= 8'(seg);
    repeat (2) @(posedge clk);
    chk({7'h00, rbit}, {7'h00, x});
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ifs = 1'b1;
    sty = 1'b0;
    crev = 1'b0;
    rcom = 7'h00;
    rseg = 8'h00;
    void'($urandom(32'hb34b8064));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({6'h00, busy, oe}, 8'h00);
    at(4'h0, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom);
      wd(d[i]);
    end
    at(4'h0, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rdd();
      chk(q, d[i]);
    end
    host_u.cyc(1'b1, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    for (int b = 0; b < 8; b++) rf(b, 0, d[0][line_of(b, 0, 1'b0)]);
    // Column stops at the last column, no wrap
    at(4'h0, 8'h82, 1'b0);
    e = 8'($urandom);
    wd(e);
    wd(8'h3c);
    wd(8'hc3);
    at(4'h0, 8'h82, 1'b1);
    rdd();
    chk(q, e);
    rdd();
    chk(q, 8'hc3);
    at(4'h8, 8'h05, 1'b0);
    wd(8'hff);
    at(4'h8, 8'h05, 1'b1);
    rdd();
    chk(q, 8'h01);
    // Scroll by three lines, columns mirrored
    cmd(8'h43);
    cmd(8'ha1);
    rf(0, 131, d[0][line_of(0, 3, 1'b0)]);
    rf(62, 131, d[0][line_of(62, 3, 1'b0)]);
    crev <= 1'b1;
    rf(63, 131, d[0][line_of(63, 3, 1'b1)]);
    crev <= 1'b0;
    cmd(8'h40);
    cmd(8'ha0);
    // Either select inactive: writes lost, bus floats
    host_u.sel(1'b1, 1'b1);
    at(4'h0, 8'h00, 1'b0);
    wd(8'h5a);
    host_u.sel(1'b0, 1'b0);
    rdd();
    chk(q, 8'hxx);
    host_u.sel(1'b0, 1'b1);
    at(4'h0, 8'h00, 1'b1);
    rdd();
    chk(q, d[0]);
    // 6800 style, switched while deselected
    host_u.sel(1'b0, 1'b0);
    sty <= 1'b1;
    host_u.idle();
    host_u.sel(1'b0, 1'b1);
    e = 8'($urandom);
    at(4'h1, 8'h07, 1'b0);
    wd(e);
    at(4'h1, 8'h07, 1'b1);
    rdd();
    chk(q, e);
    // Serial: torn byte then address and data
    host_u.sel(1'b0, 1'b0);
    ifs <= 1'b0;
    host_u.sel(1'b0, 1'b1);
    host_u.sbyte(1'b1, 8'hff, 3);
    host_u.sel(1'b0, 1'b0);
    host_u.sel(1'b0, 1'b1);
    host_u.sbyte(1'b0, 8'hb2, 8);
    host_u.sbyte(1'b0, 8'h10, 8);
    host_u.sbyte(1'b0, 8'h04, 8);
    e = 8'($urandom);
    host_u.sbyte(1'b1, e, 8);
    rdd();
    chk(q, 8'hxx);
    host_u.sel(1'b0, 1'b0);
    ifs <= 1'b1;
    host_u.sel(1'b0, 1'b1);
    at(4'h2, 8'h04, 1'b1);
    rdd();
    chk(q, e);
    print_verdict();
  end
endmodule
`default_nettype wire
